//--- shared/dsr_consts.vh
// Offsets, field positions, reset values and encodings of the diagnostic status registers.
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH
`define DSR_ADDR_W 6
`define DSR_OFS_FRONT_END 6'h0d
`define DSR_OFS_SYSTEM 6'h0e
`define DSR_OFS_CONV_STATUS 6'h08
`define DSR_OFS_TEST_CONFIG 6'h0f
`define DSR_RST_FRONT_END 16'h8000
`define DSR_RST_SYSTEM 16'h0000
`define DSR_FE_POWER_UP 15
`define DSR_FE_DIAG_FAIL 12
`define DSR_FE_TEMP_DIAG 11
`define DSR_FE_HALL_Z 10
`define DSR_FE_HALL_X 8
`define DSR_FE_TRIM 1
`define DSR_FE_REGULATOR 0
`define DSR_FE_STICKY_MASK 16'h9f03
`define DSR_SYS_NOTIFY_LVL 15
`define DSR_SYS_NOTIFY_DRV 14
`define DSR_SYS_SOUT_DRV 13
`define DSR_SYS_CRC 12
`define DSR_SYS_FRAME 11
`define DSR_SYS_STATE_HI 10
`define DSR_SYS_STATE_LO 8
`define DSR_SYS_OV 5
`define DSR_SYS_UV 4
`define DSR_SYS_TEMP_THRESHOLD_CROSS 3
`define DSR_SYS_Z_THX 2
`define DSR_SYS_X_THX 0
`define DSR_SYS_STICKY_MASK 16'h783f
`define DSR_CRC_DISABLE_BIT 2
`define DSR_STATE_SLEEP 3'h6
`endif

//--- hw/dsr_sync2.v
// Two-flop synchroniser for pin levels.
`default_nettype none
module dsr_sync2 #(
   parameter W = 1
) (
   input wire clock, // System clock.
   input wire rst_b, // Synchronous reset, active low.
   input wire [W-1:0] async_in, // Level from outside the clock domain.
   output wire [W-1:0] sync_out // Synchronised level.
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   always @(posedge clock) begin
      if (!rst_b) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule
`default_nettype wire

//--- hw/dsr_sticky.v
// Bank of sticky flags, set by events and cleared by a read, with set winning.
`default_nettype none
module dsr_sticky #(
   parameter W = 16,
   parameter [W-1:0] RESET_VAL = {W{1'b0}},
   parameter [W-1:0] MASK = {W{1'b1}}
) (
   input wire clock, // System clock.
   input wire rst_b, // Synchronous reset, active low.
   input wire [W-1:0] set_in, // One bit per flag event.
   input wire clear_in, // Read-clear strobe.
   output wire [W-1:0] flags // Current flags.
);
   reg [W-1:0] flags_q;
   wire [W-1:0] flags_d;
   // Masked bits never hold state, so reserved bits stay zero.
   assign flags_d = ((clear_in ? {W{1'b0}} : flags_q) | set_in) & MASK; // [RQ21]
   always @(posedge clock) begin
      if (!rst_b) begin
         flags_q <= RESET_VAL;
      end else begin
         flags_q <= flags_d;
      end
   end
   assign flags = flags_q;
endmodule
`default_nettype wire

//--- hw/dsr_status_regs.v
// Diagnostic status registers: front-end and system fault flags with read-clear.
`include "dsr_consts.vh"
`default_nettype none
// Summary of operation
// RQ1: Power-up flag bit 15 set by hardware reset; front-end register resets to 8000h.
// RQ2: Reading front-end register clears power-up flag until next reset.
// RQ3: Front-end diagnostic failure sets bit 12, held until front-end read.
// RQ4: Temperature sensor diagnostic failure sets bit 11, cleared on front-end read.
// RQ5: Hall failures set bits 10 Z, 9 Y, 8 X; front-end read clears.
// RQ6: Trim data error sets bit 1; front-end read clears it.
// RQ7: Regulator fault sets bit 0; front-end read clears it.
// RQ8: System bit 15 shows live notify line level, not sticky.
// RQ9: Notify line driven but not low sets bit 14; read clears.
// RQ10: Serial output mismatch while driving sets bit 13; read clears.
// RQ11: Failed transaction CRC sets bit 12; system read clears.
// RQ12: Wrong clock edge count in frame sets bit 11; system read clears.
// RQ13: Bits 10-8 report operating state, codes 0h to 6h.
// RQ14: Supply over-voltage in active or standby sets bit 5 until read.
// RQ15: Supply under-voltage in active or standby sets bit 4 until read.
// RQ16: Temperature threshold crossing sets bit 3; system read clears.
// RQ17: Magnetic threshold crossings set bits 2 Z, 1 Y, 0 X; read clears.
// RQ18: Notify summary reads 1h front-end, 2h system, 3h both flagged.
// RQ19: CRC checking on by default; crc_disable set to 1 turns it off.
// RQ20: Reserved bits read zero; read-clear leaves level and state fields alone.
// RQ21: An event in the read cycle keeps its flag set afterwards.
module dsr_status_regs (
   input wire clock, // System clock, 50 MHz.
   input wire rst_b, // Synchronous reset, active low; power-on or brown-out.
   input wire reg_rd, // Register read strobe, one cycle.
   input wire reg_wr, // Register write strobe, one cycle.
   input wire [`DSR_ADDR_W-1:0] reg_addr, // Register offset.
   input wire [15:0] reg_wdata, // Write data.
   output reg [15:0] reg_rdata, // Read data, registered.
   output reg reg_rvalid, // Read data valid, one cycle.
   input wire front_end_diag_fail, // Front-end diagnostic failure event.
   input wire temp_sensor_diag_fail, // Temperature sensor diagnostic failure event.
   input wire z_hall_diag_fail, // Z Hall diagnostic failure event.
   input wire y_hall_diag_fail, // Y Hall diagnostic failure event.
   input wire x_hall_diag_fail, // X Hall diagnostic failure event.
   input wire trim_error, // Trim data error event.
   input wire regulator_fault, // Internal regulator fault event.
   input wire notify_line_pin, // Notify line feedback from the pin.
   input wire notify_drive, // Device is driving the notify line low.
   input wire serial_out_pin, // Serial output pin feedback.
   input wire serial_out_value, // Value the device drives on the serial output.
   input wire serial_out_en, // Serial output is being driven.
   input wire crc_fail, // Transaction failed its CRC, one-cycle pulse.
   input wire frame_edge_error, // Wrong clock edge count in a frame, pulse.
   input wire [2:0] operating_state, // Current operating state code.
   input wire supply_ov_detect, // Supply over-voltage detector.
   input wire supply_uv_detect, // Supply under-voltage detector.
   input wire temp_threshold_cross, // Temperature threshold crossing event.
   input wire z_threshold_cross, // Z magnetic threshold crossing event.
   input wire y_threshold_cross, // Y magnetic threshold crossing event.
   input wire x_threshold_cross, // X magnetic threshold crossing event.
   output wire [1:0] notify_summary, // Flag summary for the conversion status.
   output wire crc_disable // Configured CRC checking off.
);

   // ==========================================================
   // Pin feedback synchronisation
   // ==========================================================
   wire [1:0] pin_sync;
   wire notify_line_level;
   wire serial_out_fb;
   dsr_sync2 #(
      .W(2)
   ) u_pin_sync (
      .clock(clock),
      .rst_b(rst_b),
      .async_in({notify_line_pin, serial_out_pin}),
      .sync_out(pin_sync)
   );
   assign notify_line_level = pin_sync[1];
   assign serial_out_fb = pin_sync[0];

   // The driven values are delayed to line up with the synchronised feedback.
   reg [1:0] notify_drive_q;
   reg [1:0] sout_val_q;
   reg [1:0] sout_en_q;
   always @(posedge clock) begin
      if (!rst_b) begin
         notify_drive_q <= 2'h0;
         sout_val_q <= 2'h0;
         sout_en_q <= 2'h0;
      end else begin
         notify_drive_q <= {notify_drive_q[0], notify_drive};
         sout_val_q <= {sout_val_q[0], serial_out_value};
         sout_en_q <= {sout_en_q[0], serial_out_en};
      end
   end

   // ==========================================================
   // Decode helpers
   // ==========================================================
   localparam [2:0] ST_STANDBY = 3'h1;
   localparam [2:0] ST_CONTINUOUS = 3'h2;
   localparam [2:0] ST_TRIGGERED = 3'h3;
   localparam [2:0] ST_DUTY_ACTIVE = 3'h4;

   // True when a strobe addresses the given register offset.
   function addr_hit;
      input strobe;
      input [`DSR_ADDR_W-1:0] addr;
      input [`DSR_ADDR_W-1:0] offset;
      begin
         addr_hit = strobe && addr == offset;
      end
   endfunction

   // Supply monitoring counts only in standby and the active states.
   function supply_watched;
      input [2:0] state;
      begin
         case (state)
            ST_STANDBY: supply_watched = 1'b1;
            ST_CONTINUOUS: supply_watched = 1'b1;
            ST_TRIGGERED: supply_watched = 1'b1;
            ST_DUTY_ACTIVE: supply_watched = 1'b1;
            default: supply_watched = 1'b0;
         endcase
      end
   endfunction

   // ==========================================================
   // Configuration: CRC disable in the test configuration register
   // ==========================================================
   reg crc_disable_q;
   always @(posedge clock) begin
      if (!rst_b) begin
         crc_disable_q <= 1'b0; // [RQ19]
      end else if (addr_hit(reg_wr, reg_addr, `DSR_OFS_TEST_CONFIG)) begin
         crc_disable_q <= reg_wdata[`DSR_CRC_DISABLE_BIT]; // [RQ19]
      end
   end
   assign crc_disable = crc_disable_q;

   // ==========================================================
   // Read decode
   // ==========================================================
   wire rd_front_end;
   wire rd_system;
   assign rd_front_end = addr_hit(reg_rd, reg_addr, `DSR_OFS_FRONT_END); // [RQ2]
   assign rd_system = addr_hit(reg_rd, reg_addr, `DSR_OFS_SYSTEM);

   // ==========================================================
   // Front-end fault flags
   // ==========================================================
   reg [15:0] fe_set;
   always @* begin
      fe_set = 16'h0000;
      fe_set[`DSR_FE_DIAG_FAIL] = front_end_diag_fail; // [RQ3]
      fe_set[`DSR_FE_TEMP_DIAG] = temp_sensor_diag_fail; // [RQ4]
      fe_set[`DSR_FE_HALL_Z:`DSR_FE_HALL_X] = {z_hall_diag_fail, y_hall_diag_fail, x_hall_diag_fail}; // [RQ5]
      fe_set[`DSR_FE_TRIM] = trim_error; // [RQ6]
      fe_set[`DSR_FE_REGULATOR] = regulator_fault; // [RQ7]
   end

   wire [15:0] front_end_fault_status;
   // Power-up flag comes from the reset value only; set beats clear. [RQ1] [RQ21]
   dsr_sticky #(
      .W(16),
      .RESET_VAL(`DSR_RST_FRONT_END), // [RQ1]
      .MASK(`DSR_FE_STICKY_MASK)
   ) u_front_end (
      .clock(clock),
      .rst_b(rst_b),
      .set_in(fe_set),
      .clear_in(rd_front_end), // [RQ2]
      .flags(front_end_fault_status)
   );

   // ==========================================================
   // System fault flags
   // ==========================================================
   reg [15:0] sys_set;
   always @* begin
      sys_set = 16'h0000;
      sys_set[`DSR_SYS_NOTIFY_DRV] = notify_drive_q[1] && notify_line_level; // [RQ9]
      sys_set[`DSR_SYS_SOUT_DRV] = sout_en_q[1] && (sout_val_q[1] != serial_out_fb); // [RQ10]
      sys_set[`DSR_SYS_CRC] = crc_fail && !crc_disable_q; // [RQ11] [RQ19]
      sys_set[`DSR_SYS_FRAME] = frame_edge_error; // [RQ12]
      sys_set[`DSR_SYS_OV] = supply_ov_detect && supply_watched(operating_state); // [RQ14]
      sys_set[`DSR_SYS_UV] = supply_uv_detect && supply_watched(operating_state); // [RQ15]
      sys_set[`DSR_SYS_TEMP_THRESHOLD_CROSS] = temp_threshold_cross; // [RQ16]
      sys_set[`DSR_SYS_Z_THX:`DSR_SYS_X_THX] = {z_threshold_cross, y_threshold_cross, x_threshold_cross}; // [RQ17]
   end

   wire [15:0] sys_flags;
   dsr_sticky #(
      .W(16),
      .RESET_VAL(`DSR_RST_SYSTEM),
      .MASK(`DSR_SYS_STICKY_MASK)
   ) u_system (
      .clock(clock),
      .rst_b(rst_b),
      .set_in(sys_set),
      .clear_in(rd_system), // [RQ21]
      .flags(sys_flags)
   );

   // Level and state fields are merged live and never cleared.
   reg [15:0] system_fault_status;
   always @* begin
      system_fault_status = sys_flags; // [RQ20]
      system_fault_status[`DSR_SYS_NOTIFY_LVL] = notify_line_level; // [RQ8]
      system_fault_status[`DSR_SYS_STATE_HI:`DSR_SYS_STATE_LO] = operating_state; // [RQ13]
   end

   // ==========================================================
   // Notify summary
   // ==========================================================
   assign notify_summary = {|sys_flags, |front_end_fault_status}; // [RQ18]

   // ==========================================================
   // Read data path
   // ==========================================================
   always @(posedge clock) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `DSR_OFS_FRONT_END: reg_rdata <= front_end_fault_status;
               `DSR_OFS_SYSTEM: reg_rdata <= system_fault_status;
               `DSR_OFS_CONV_STATUS: reg_rdata <= {14'h0, notify_summary}; // [RQ18]
               `DSR_OFS_TEST_CONFIG: reg_rdata <= {13'h0, crc_disable_q, 2'h0};
               default: reg_rdata <= 16'h0000; // [RQ20]
            endcase
         end
      end
   end

endmodule
`default_nettype wire

//--- verif/dsr_status_regs_sva.sv
// Assertions on the diagnostic status register ports.
`include "dsr_consts.vh"
`default_nettype none
module dsr_status_regs_sva (
   input wire clock, // Clock.
   input wire rst_b, // Reset.
   input wire reg_rd, // Read.
   input wire [`DSR_ADDR_W-1:0] reg_addr, // Offset.
   input wire [15:0] reg_rdata, // Data.
   input wire reg_rvalid, // Valid.
   input wire front_end_diag_fail, // Event.
   input wire temp_sensor_diag_fail, // Event.
   input wire z_hall_diag_fail, // Event.
   input wire y_hall_diag_fail, // Event.
   input wire x_hall_diag_fail, // Event.
   input wire trim_error, // Event.
   input wire regulator_fault, // Event.
   input wire crc_fail, // Event.
   input wire crc_disable, // Config.
   input wire [2:0] operating_state, // State.
   input wire supply_ov_detect, // Event.
   input wire x_threshold_cross, // Event.
   input wire [1:0] notify_summary // Summary.
);
   timeunit 1ns;
   timeprecision 1ns;
   wire rfe = reg_rd && reg_addr == `DSR_OFS_FRONT_END;
   wire rsy = reg_rd && reg_addr == `DSR_OFS_SYSTEM;
   wire fev = front_end_diag_fail | temp_sensor_diag_fail | z_hall_diag_fail | y_hall_diag_fail |
      x_hall_diag_fail | trim_error | regulator_fault;
   // Remembers that the front-end register has been read since reset.
   logic fe_rd_seen_q;
   always @(posedge clock) begin
      if (!rst_b) begin
         fe_rd_seen_q <= 1'b0;
      end else if (rfe) begin
         fe_rd_seen_q <= 1'b1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_pu_clear; reg_rvalid && $past(rfe) && $past(fe_rd_seen_q) |-> reg_rdata[15] == 1'b0; endproperty
   a_pu_clear: assert property (p_pu_clear) else $error("power-up flag not cleared");
   property p_fe_resv; reg_rvalid && $past(reg_addr) == `DSR_OFS_FRONT_END |-> (reg_rdata & 16'h60fc) == 16'h0; endproperty
   a_fe_resv: assert property (p_fe_resv) else $error("front-end reserved bits set");
   property p_sys_resv; reg_rvalid && $past(reg_addr) == `DSR_OFS_SYSTEM |-> (reg_rdata & 16'h00c0) == 16'h0; endproperty
   a_sys_resv: assert property (p_sys_resv) else $error("system reserved bits set");
   property p_state; rsy |=> reg_rdata[10:8] == $past(operating_state); endproperty
   a_state: assert property (p_state) else $error("state field wrong");
   property p_fe_diag; front_end_diag_fail ##1 rfe |=> reg_rdata[12]; endproperty
   a_fe_diag: assert property (p_fe_diag) else $error("front-end fail lost");
   property p_crc; crc_fail && !crc_disable ##1 rsy |=> reg_rdata[12]; endproperty
   a_crc: assert property (p_crc) else $error("crc flag lost");
   property p_ov; supply_ov_detect && operating_state inside {[3'h1:3'h4]} ##1 rsy |=> reg_rdata[5]; endproperty
   a_ov: assert property (p_ov) else $error("over-voltage lost");
   property p_x_thx; x_threshold_cross ##1 rsy |=> reg_rdata[0]; endproperty
   a_x_thx: assert property (p_x_thx) else $error("crossing lost");
   property p_summary; rfe && !fev |=> notify_summary[0] == 1'b0; endproperty
   a_summary: assert property (p_summary) else $error("summary not cleared");
   property p_hold; x_threshold_cross && rsy ##1 !rsy ##1 rsy |=> reg_rdata[0]; endproperty
   a_hold: assert property (p_hold) else $error("event lost in read");
   c_fe: cover property (rfe);
   c_crc_off: cover property (crc_fail && crc_disable);
   c_hold: cover property (x_threshold_cross && rsy);
endmodule
bind dsr_status_regs dsr_status_regs_sva i_sva (.*);
`default_nettype wire

//--- verif/dsr_host_model.sv
// Host model that reads and writes the status registers.
`default_nettype none
module dsr_host_model (
   input wire logic clock, // Clock.
   output logic reg_rd, // Read strobe.
   output logic reg_wr, // Write strobe.
   output logic [5:0] reg_addr, // Offset.
   output logic [15:0] reg_wdata, // Write data.
   input wire logic [15:0] reg_rdata, // Read data.
   input wire logic reg_rvalid // Read valid.
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
   end
   // Both tasks are entered just after a falling edge.
   task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      d = reg_rdata;
      v = reg_rvalid;
      reg_rd = 1'b0;
      @(negedge clock);
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] w);
      reg_addr = a;
      reg_wdata = w;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      @(negedge clock);
   endtask
endmodule
`default_nettype wire

//--- verif/tb_dsr_status_regs.sv
// Self-checking testbench for the diagnostic status registers.
`include "dsr_consts.vh"
`default_nettype none
module tb_dsr_status_regs;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [5:0] FE = `DSR_OFS_FRONT_END, SY = `DSR_OFS_SYSTEM, CV = `DSR_OFS_CONV_STATUS;
   logic clock, rst_b, reg_rd, reg_wr, reg_rvalid, crc_disable, v, ndrv, nok, sflt, notify_drive;
   logic serial_out_en, serial_out_value;
   logic [5:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [1:0] notify_summary;
   logic [2:0] operating_state;
   logic [6:0] fe_ev;
   logic [7:0] sys_ev;
   int n_fail, checked, i;
   int fep[7] = '{0, 1, 8, 9, 10, 11, 12};
   int sysp[8] = '{0, 1, 2, 3, 4, 5, 11, 12};
   wire regulator_fault = fe_ev[0], trim_error = fe_ev[1], x_hall_diag_fail = fe_ev[2];
   wire y_hall_diag_fail = fe_ev[3], z_hall_diag_fail = fe_ev[4], temp_sensor_diag_fail = fe_ev[5];
   wire front_end_diag_fail = fe_ev[6], x_threshold_cross = sys_ev[0], y_threshold_cross = sys_ev[1];
   wire z_threshold_cross = sys_ev[2], temp_threshold_cross = sys_ev[3], supply_uv_detect = sys_ev[4];
   wire supply_ov_detect = sys_ev[5], frame_edge_error = sys_ev[6], crc_fail = sys_ev[7];
   // Open-drain notify line with pull-up; nok low models a line that cannot be pulled down.
   wire notify_line_pin = ~(notify_drive & nok);
   wire serial_out_pin = serial_out_en ? serial_out_value ^ sflt : 1'b1;
   dsr_status_regs i_dut (.*);
   dsr_host_model i_host (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [15:0] e);
      i_host.rd(a, d, v);
      chk({15'h0, v}, 16'h1);
      chk(d, e);
   endtask
   task automatic pulse_ev(input logic [6:0] f, input logic [7:0] s);
      fe_ev = f;
      sys_ev = s;
      @(negedge clock);
      fe_ev = 7'h0;
      sys_ev = 8'h0;
   endtask
   task automatic complete_run;
      if (n_fail == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // The sequence takes well under 1000 cycles.
   initial begin
      #100us;
      n_fail++;
      complete_run();
   end
   initial begin
      {rst_b, fe_ev, sys_ev, operating_state, notify_drive, sflt, serial_out_en, serial_out_value} = '0;
      nok = 1'b1;
      n_fail = 0;
      checked = 0;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      repeat (2) @(negedge clock);
      rchk(FE, 16'h8000);
      rchk(FE, 16'h0000);
      rchk(SY, 16'h8000);
      rchk(6'h3f, 16'h0000);
      for (i = 0; i < 7; i++) begin
         pulse_ev(7'h1 << i, 8'h0);
         rchk(FE, 16'h1 << fep[i]);
         rchk(FE, 16'h0000);
      end
      operating_state = 3'h1;
      for (i = 0; i < 8; i++) begin
         pulse_ev(7'h0, 8'h1 << i);
         rchk(SY, 16'h8100 | (16'h1 << sysp[i]));
         rchk(SY, 16'h8100);
      end
      pulse_ev(7'h40, 8'h01);
      chk({14'h0, notify_summary}, 16'h3);
      rchk(CV, 16'h0003);
      rchk(FE, 16'h1000);
      rchk(CV, 16'h0002);
      rchk(SY, 16'h8101);
      rchk(CV, 16'h0000);
      for (i = 0; i < 7; i++) begin
         operating_state = i[2:0];
         rchk(SY, 16'h8000 | (i[15:0] << 8));
      end
      pulse_ev(7'h0, 8'h30);
      rchk(SY, 16'h8600);
      operating_state = 3'h0;
      nok = 1'b0;
      notify_drive = 1'b1;
      @(negedge clock);
      notify_drive = 1'b0;
      repeat (3) @(negedge clock);
      rchk(SY, 16'hc000);
      nok = 1'b1;
      notify_drive = 1'b1;
      repeat (4) @(negedge clock);
      rchk(SY, 16'h0000);
      notify_drive = 1'b0;
      {serial_out_en, sflt} = 2'b11;
      @(negedge clock);
      {serial_out_en, sflt} = 2'b00;
      repeat (3) @(negedge clock);
      rchk(SY, 16'ha000);
      i_host.wr(`DSR_OFS_TEST_CONFIG, 16'h0004);
      chk({15'h0, crc_disable}, 16'h1);
      pulse_ev(7'h0, 8'h80);
      rchk(SY, 16'h8000);
      i_host.wr(`DSR_OFS_TEST_CONFIG, 16'h0000);
      sys_ev = 8'h01;
      fork
         i_host.rd(SY, d, v);
         begin
            @(negedge clock);
            sys_ev = 8'h00;
         end
      join
      chk(d, 16'h8000);
      rchk(SY, 16'h8001);
      i_host.wr(`DSR_OFS_TEST_CONFIG, 16'h0004);
      rst_b = 1'b0;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      @(negedge clock);
      chk({15'h0, crc_disable}, 16'h0);
      rchk(FE, 16'h8000);
      complete_run();
   end
endmodule
`default_nettype wire
